//--- hdl/dcc_pkg.sv
// Constants, register layout and carrier types of the dual comparator control block.
// Function
// (R1) Comparator A result reads 1 when plus input above minus input, inversion off.
// (R2) Comparator A result reads 0 when plus above minus, inversion on.
// (R3) Comparator B invert bit inverts both its result bit and pad output.
// (R4) Comparator A invert bit inverts its output; clear passes it unchanged.
// (R5) Comparator B minus select: 1 picks plus input pin, 0 minus input pin.
// (R6) Comparator B plus select: 1 picks plus input pin, 0 internal reference.
// (R7) Comparator A minus select: 1 picks plus input pin, 0 minus input pin.
// (R8) Comparator A plus select: 1 picks plus input pin, 0 internal reference.
// (R9) Comparator A pad drive bit set drives its output on the pad.
// (R10) Comparator B pad drive bit drives its output; software routes it to a pin.
// (R11) Each comparator works only while its enable bit is set.
// (R12) Output change sets a sticky change flag until software clears it.
// (R13) Raw comparator results are synchronised before status and event use.
package dcc_pkg;

    localparam int          DCC_DATA_W     = 16;
    localparam int          DCC_ADDR_W     = 4;
    localparam int          DCC_SYNC_LAT   = 3;

    localparam logic [3:0]  DCC_OFS_CTRL   = 4'h0;
    localparam logic [3:0]  DCC_OFS_STAT   = 4'h1;
    localparam logic [3:0]  DCC_OFS_MASK   = 4'h2;

    localparam logic [15:0] DCC_CTRL_RST   = 16'h0000;
    localparam logic [15:0] DCC_CTRL_WMASK = 16'h8F3F;
    localparam logic [1:0]  DCC_EVT_RST    = 2'h0;

    typedef struct packed {
        logic idle_stop;
        logic unused14;
        logic cmp_b_change_flag;
        logic cmp_a_change_flag;
        logic cmp_b_on;
        logic cmp_a_on;
        logic cmp_b_pad_drive;
        logic cmp_a_pad_drive;
        logic cmp_b_result;
        logic cmp_a_result;
        logic cmp_b_invert;
        logic cmp_a_invert;
        logic cmp_b_minus_select;
        logic cmp_b_plus_select;
        logic cmp_a_minus_select;
        logic cmp_a_plus_select;
    } dcc_ctrl_t;

    typedef struct packed {
        logic out;
        logic oe;
    } dcc_pad_t;

endpackage

//--- hdl/dcc_top.sv
// Register bank, synchronisers and event logic of the dual comparator control block.
`timescale 1ns/1ps
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST_B,
    input  wire logic [DCC_ADDR_W-1:0] ADDR,
    input  wire logic [DCC_DATA_W-1:0] WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output logic      [DCC_DATA_W-1:0] RDATA,
    input  wire logic                  CMP_A_RAW,
    input  wire logic                  CMP_B_RAW,
    output logic                       CMP_A_ON,
    output logic                       CMP_B_ON,
    output logic                       CMP_A_PLUS_SELECT,
    output logic                       CMP_A_MINUS_SELECT,
    output logic                       CMP_B_PLUS_SELECT,
    output logic                       CMP_B_MINUS_SELECT,
    output dcc_pad_t                   CMP_A_PAD,
    output dcc_pad_t                   CMP_B_PAD,
    output logic                       IRQ
);

    dcc_ctrl_t        ctrl_reg;
    logic [1:0]       sync1_reg;
    logic [1:0]       sync2_reg;
    logic [1:0]       prev_reg;
    logic [1:0]       on_d_reg;
    logic [1:0]       result_reg;
    logic [1:0]       flag_reg;
    logic [1:0]       flag_next;
    logic [1:0]       stat_reg;
    logic [1:0]       stat_next;
    logic [1:0]       mask_reg;
    logic [1:0]       mask_next;
    logic             irq_reg;
    logic [15:0]      rdata_reg;
    logic [1:0]       on_vec;
    logic [1:0]       inv_vec;
    logic [1:0]       cmp_val;
    logic [1:0]       chg;
    logic [1:0]       flag_clr;
    logic             wr_ctrl;
    logic             wr_mask;
    logic             rd_stat;
    dcc_ctrl_t        ctrl_view;
    logic [2:0]       warm_reg;
    logic [DCC_SYNC_LAT-1:0] on_hist_a_reg;
    logic [DCC_SYNC_LAT-1:0] on_hist_b_reg;
    logic [1:0]       settled;

    assign on_vec  = {ctrl_reg.cmp_b_on, ctrl_reg.cmp_a_on};
    assign inv_vec = {ctrl_reg.cmp_b_invert, ctrl_reg.cmp_a_invert};
    assign wr_ctrl = WR && (ADDR == DCC_OFS_CTRL);
    assign wr_mask = WR && (ADDR == DCC_OFS_MASK);
    assign rd_stat = RD && (ADDR == DCC_OFS_STAT);

    // The first stage feeds only the second stage.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
        end else begin
            sync1_reg <= {CMP_B_RAW, CMP_A_RAW};
            sync2_reg <= sync1_reg; // [R13]
        end
    end

    // A disabled comparator is seen as a steady low.
    assign cmp_val = sync2_reg & on_vec; // [R11]

    // Changes are taken from the raw comparison, so toggling inversion raises no event.
    // A core that was just enabled leaves samples of its idle output in the synchroniser.
    // Events wait until every stage holds a sample taken while the core was enabled.
    assign settled = {&on_hist_b_reg, &on_hist_a_reg};
    assign chg     = on_vec & on_d_reg & settled & (cmp_val ^ prev_reg); // [R12] [R13]

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            on_hist_a_reg <= '0;
            on_hist_b_reg <= '0;
        end else begin
            on_hist_a_reg <= {on_hist_a_reg[DCC_SYNC_LAT-2:0], on_vec[0]};
            on_hist_b_reg <= {on_hist_b_reg[DCC_SYNC_LAT-2:0], on_vec[1]};
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            prev_reg <= 2'h0;
            on_d_reg <= 2'h0;
        end else begin
            prev_reg <= cmp_val;
            on_d_reg <= on_vec;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            result_reg <= 2'h0;
        end else begin
            result_reg <= (cmp_val ^ inv_vec) & on_vec; // [R1] [R2] [R3] [R4] [R11]
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_reg <= dcc_ctrl_t'(DCC_CTRL_RST);
        end else if (wr_ctrl) begin
            ctrl_reg <= dcc_ctrl_t'(WDATA & DCC_CTRL_WMASK); // [R5] [R6] [R7] [R8] [R9] [R10]
        end
    end

    // Writing 0 clears a change flag, writing 1 leaves it; a new change wins.
    assign flag_clr  = wr_ctrl ? ~{WDATA[13], WDATA[12]} : 2'h0;
    assign flag_next = (flag_reg & ~flag_clr) | chg; // [R12]

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flag_reg <= DCC_EVT_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Interrupt status is cleared by reading it; a change in that cycle survives.
    assign stat_next = (rd_stat ? 2'h0 : stat_reg) | chg;
    assign mask_next = wr_mask ? WDATA[1:0] : mask_reg;

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            stat_reg <= DCC_EVT_RST;
            mask_reg <= DCC_EVT_RST;
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            irq_reg  <= |(stat_next & mask_next);
        end
    end

    always_comb begin
        ctrl_view                   = ctrl_reg;
        ctrl_view.cmp_a_change_flag = flag_reg[0];
        ctrl_view.cmp_b_change_flag = flag_reg[1];
        ctrl_view.cmp_a_result      = result_reg[0];
        ctrl_view.cmp_b_result      = result_reg[1];
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= 16'h0000;
        end else if (RD) begin
            if (ADDR == DCC_OFS_CTRL) begin
                rdata_reg <= ctrl_view;
            end else if (ADDR == DCC_OFS_STAT) begin
                rdata_reg <= {14'h0000, stat_reg};
            end else if (ADDR == DCC_OFS_MASK) begin
                rdata_reg <= {14'h0000, mask_reg};
            end else begin
                rdata_reg <= 16'h0000;
            end
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign RDATA              = rdata_reg;
    assign IRQ                = irq_reg;
    assign CMP_A_ON           = ctrl_reg.cmp_a_on;
    assign CMP_B_ON           = ctrl_reg.cmp_b_on;
    assign CMP_A_PLUS_SELECT  = ctrl_reg.cmp_a_plus_select;  // [R8]
    assign CMP_A_MINUS_SELECT = ctrl_reg.cmp_a_minus_select; // [R7]
    assign CMP_B_PLUS_SELECT  = ctrl_reg.cmp_b_plus_select;  // [R6]
    assign CMP_B_MINUS_SELECT = ctrl_reg.cmp_b_minus_select; // [R5]
    assign CMP_A_PAD          = '{out: result_reg[0], oe: ctrl_reg.cmp_a_pad_drive}; // [R9]
    assign CMP_B_PAD          = '{out: result_reg[1], oe: ctrl_reg.cmp_b_pad_drive}; // [R10]

    // Helper for the checks: counts the first cycles after reset release.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            warm_reg <= 3'h0;
        end else if (warm_reg != 3'h5) begin
            warm_reg <= warm_reg + 3'h1;
        end
    end

    property p_a_plain_high;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (ctrl_reg.cmp_a_on && !ctrl_reg.cmp_a_invert && CMP_A_RAW)[*4] |-> result_reg[0];
    endproperty
    a_a_plain_high: assert property (p_a_plain_high) else $error("A result not high"); // [R1]

    property p_a_plain_low;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (ctrl_reg.cmp_a_on && !ctrl_reg.cmp_a_invert && !CMP_A_RAW)[*4] |-> !result_reg[0];
    endproperty
    a_a_plain_low: assert property (p_a_plain_low) else $error("A result not low"); // [R1]

    property p_a_inv_high;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (ctrl_reg.cmp_a_on && ctrl_reg.cmp_a_invert && CMP_A_RAW)[*4] |-> !result_reg[0];
    endproperty
    a_a_inv_high: assert property (p_a_inv_high) else $error("A inverted result wrong"); // [R2]

    property p_a_inv_pad;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (ctrl_reg.cmp_a_on && ctrl_reg.cmp_a_invert && !CMP_A_RAW)[*4] |-> CMP_A_PAD.out;
    endproperty
    a_a_inv_pad: assert property (p_a_inv_pad) else $error("A pad not inverted"); // [R4]

    property p_b_inv;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (ctrl_reg.cmp_b_on && ctrl_reg.cmp_b_invert && !CMP_B_RAW)[*4]
        |-> result_reg[1] && CMP_B_PAD.out;
    endproperty
    a_b_inv: assert property (p_b_inv) else $error("B output not inverted"); // [R3]

    property p_b_plain;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (ctrl_reg.cmp_b_on && !ctrl_reg.cmp_b_invert && CMP_B_RAW)[*4]
        |-> result_reg[1] && CMP_B_PAD.out;
    endproperty
    a_b_plain: assert property (p_b_plain) else $error("B output wrongly inverted"); // [R3]

    property p_sel_write;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (WR && ADDR == DCC_OFS_CTRL) |=> {CMP_B_MINUS_SELECT, CMP_B_PLUS_SELECT,
            CMP_A_MINUS_SELECT, CMP_A_PLUS_SELECT} == $past(WDATA[3:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("Input select not taken"); // [R5] [R6] [R7] [R8]

    property p_pad_write;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (WR && ADDR == DCC_OFS_CTRL) |=> {CMP_B_PAD.oe, CMP_A_PAD.oe} == $past(WDATA[9:8]);
    endproperty
    a_pad_write: assert property (p_pad_write) else $error("Pad drive not taken"); // [R9] [R10]

    property p_off_quiet;
        @(posedge CORE_CLK) disable iff (!RST_B)
        !CMP_A_ON |=> !result_reg[0] && !($rose(flag_reg[0]));
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("Disabled A active"); // [R11]

    property p_change_flag;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (CMP_A_ON && on_d_reg[0] && $changed(CMP_A_RAW)) ##1 CMP_A_ON[*2] |=> flag_reg[0];
    endproperty
    a_change_flag: assert property (p_change_flag) else $error("A change not flagged"); // [R12]

    property p_flag_sticky;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (flag_reg[1] && !(wr_ctrl && !WDATA[13])) |=> flag_reg[1];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("B flag lost"); // [R12]

    property p_sync_delay;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (warm_reg == 3'h5 && $changed(result_reg[0]))
        |-> ($past(CMP_A_RAW, 3) != $past(CMP_A_RAW, 4)) || ($past(ctrl_reg, 1) != $past(ctrl_reg, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("A result skipped sync"); // [R13]

    property p_irq_level;
        @(posedge CORE_CLK) disable iff (!RST_B)
        |(stat_reg & mask_reg) |-> IRQ;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt not raised");

    property p_a_inv_low;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (ctrl_reg.cmp_a_on && ctrl_reg.cmp_a_invert && !CMP_A_RAW)[*4] |-> result_reg[0];
    endproperty
    a_a_inv_low: assert property (p_a_inv_low) else $error("A inverted low result wrong"); // [R2]

    property p_b_plain_low;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (ctrl_reg.cmp_b_on && !ctrl_reg.cmp_b_invert && !CMP_B_RAW)[*4] |-> !result_reg[1] && !CMP_B_PAD.out;
    endproperty
    a_b_plain_low: assert property (p_b_plain_low) else $error("B output not low"); // [R3]

    property p_b_change_flag;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (CMP_B_ON && on_d_reg[1] && $changed(CMP_B_RAW)) ##1 CMP_B_ON[*2] |=> flag_reg[1];
    endproperty
    a_b_change_flag: assert property (p_b_change_flag) else $error("B change not flagged"); // [R12]

    property p_b_off_quiet;
        @(posedge CORE_CLK) disable iff (!RST_B)
        !CMP_B_ON |=> !result_reg[1] && !($rose(flag_reg[1]));
    endproperty
    a_b_off_quiet: assert property (p_b_off_quiet) else $error("Disabled B active"); // [R11]

    property p_flag_clear;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (wr_ctrl && !WDATA[12] && !chg[0]) |=> !flag_reg[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("A flag not cleared"); // [R12]

    property p_cfg_hold;
        @(posedge CORE_CLK) disable iff (!RST_B)
        !wr_ctrl |=> $stable(ctrl_reg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("Control changed without write"); // [R5] [R9] [R11]

    property p_unmapped;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (WR && ADDR > DCC_OFS_MASK) |=> $stable(ctrl_reg) && $stable(mask_reg);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped write took effect");

    property p_mask_write;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (WR && ADDR == DCC_OFS_MASK) |=> mask_reg == $past(WDATA[1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("Mask not taken");

    property p_stat_clear;
        @(posedge CORE_CLK) disable iff (!RST_B)
        (rd_stat && !(|chg)) |=> stat_reg == 2'h0;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("Status not cleared by read");

    property p_rdata_idle;
        @(posedge CORE_CLK) disable iff (!RST_B)
        !RD |=> RDATA == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("Read data without read");

    property p_irq_off;
        @(posedge CORE_CLK) disable iff (!RST_B)
        !(|(stat_reg & mask_reg)) |-> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("Interrupt without masked status");

    c_a_event: cover property (@(posedge CORE_CLK) disable iff (!RST_B) $rose(flag_reg[0]));
    c_stat_clear: cover property (@(posedge CORE_CLK) disable iff (!RST_B) $fell(stat_reg[0]));
    c_b_event: cover property (@(posedge CORE_CLK) disable iff (!RST_B) $rose(flag_reg[1]));
    c_irq: cover property (@(posedge CORE_CLK) disable iff (!RST_B) $rose(IRQ));
    c_inv_pad: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
        CMP_B_PAD.oe && ctrl_reg.cmp_b_invert && CMP_B_PAD.out);

endmodule // dcc_top

//--- verif/dcc_cmp_model.sv
// Behavioural model of one analog comparator core with its input selectors.
`timescale 1ns/1ps
module dcc_cmp_model (
    input  wire logic       clk,
    input  wire logic       on,
    input  wire logic       plus_select,
    input  wire logic       minus_select,
    input  wire logic [7:0] vin_plus,
    input  wire logic [7:0] vin_minus,
    input  wire logic [7:0] vref,
    output logic            raw
);
    logic [7:0] plus_v;
    logic [7:0] minus_v;
    logic       idle_q = 1'b0;
    // A powered-down core gives a level that changes every cycle.
    always @(posedge clk) begin
        idle_q <= ~idle_q;
    end
    assign plus_v  = plus_select ? vin_plus : vref;
    assign minus_v = minus_select ? vin_plus : vin_minus;
    assign raw     = on ? (plus_v > minus_v) : idle_q;
endmodule // dcc_cmp_model

//--- verif/test_dual_comparator_control.sv
// Self-checking bench of the dual comparator control block with two core models.
`timescale 1ns/1ps
module test_dual_comparator_control
    import dcc_pkg::*;
;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [7:0]  vr;
        logic [1:0]  res;
    } dcc_row_t;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd_stb = 1'b0;
    logic [7:0]  vp = 8'h14;
    logic [7:0]  vm = 8'h0A;
    logic [7:0]  vr = 8'h05;
    logic [15:0] rdata;
    logic [15:0] d;
    logic        raw_a;
    logic        raw_b;
    logic        on_a;
    logic        on_b;
    logic        irq;
    wire  [3:0]  sel;
    dcc_pad_t    pad_a;
    dcc_pad_t    pad_b;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cycles = 0;
    dcc_row_t    rows [11] = '{{16'h0C01, 8'h0F, 2'h3}, {16'h0C01, 8'h05, 2'h1}, {16'h0C00, 8'h05, 2'h0},
        {16'h0C11, 8'h05, 2'h0}, {16'h0C21, 8'h05, 2'h3}, {16'h0C02, 8'h12, 2'h2}, {16'h0C0C, 8'h1E, 2'h1},
        {16'h0C04, 8'h1E, 2'h3}, {16'h0000, 8'h1E, 2'h0}, {16'h0F01, 8'h05, 2'h1}, {16'h0930, 8'h05, 2'h2}};

    dcc_top dut_u (.CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd_stb),
        .RDATA(rdata), .CMP_A_RAW(raw_a), .CMP_B_RAW(raw_b), .CMP_A_ON(on_a), .CMP_B_ON(on_b),
        .CMP_A_PLUS_SELECT(sel[0]), .CMP_A_MINUS_SELECT(sel[1]), .CMP_B_PLUS_SELECT(sel[2]),
        .CMP_B_MINUS_SELECT(sel[3]), .CMP_A_PAD(pad_a), .CMP_B_PAD(pad_b), .IRQ(irq));
    dcc_cmp_model cmp_a_u (.clk(clk), .on(on_a), .plus_select(sel[0]), .minus_select(sel[1]),
        .vin_plus(vp), .vin_minus(vm), .vref(vr), .raw(raw_a));
    dcc_cmp_model cmp_b_u (.clk(clk), .on(on_b), .plus_select(sel[2]), .minus_select(sel[3]),
        .vin_plus(vp), .vin_minus(vm), .vref(vr), .raw(raw_b));

    always #5 clk = ~clk;

    task automatic summarize();
        if (bad_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Both tasks start and end just after a rising edge.
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
        #1 chk(rdata, 16'h0000);
        @(posedge clk);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            bad_count++;
            summarize();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        chk({11'h000, irq, pad_b, pad_a}, 16'h0000);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 3; a++) begin
            bus_rd(a[3:0], d);
            chk(d, 16'h0000);
        end
        for (int i = 0; i < 11; i++) begin
            vr <= rows[i].vr;
            bus_wr(DCC_OFS_CTRL, rows[i].ctrl);
            repeat (6) @(posedge clk);
            bus_rd(DCC_OFS_CTRL, d);
            chk(d & 16'h0FFF, (rows[i].ctrl & 16'h0F3F) | {8'h00, rows[i].res, 6'h00});
            chk({12'h000, pad_b, pad_a},
                {12'h000, rows[i].res[1], rows[i].ctrl[9], rows[i].res[0], rows[i].ctrl[8]});
            chk({10'h000, on_b, on_a, sel}, {10'h000, rows[i].ctrl[11:10], rows[i].ctrl[3:0]});
        end
        vr <= 8'h05;
        bus_wr(DCC_OFS_CTRL, 16'h0401);
        repeat (6) @(posedge clk);
        bus_wr(DCC_OFS_CTRL, 16'h0401);
        @(posedge clk);
        bus_wr(DCC_OFS_MASK, 16'h0001);
        bus_rd(DCC_OFS_STAT, d);
        bus_rd(DCC_OFS_CTRL, d);
        chk(d, 16'h0441);
        bus_rd(DCC_OFS_MASK, d);
        chk(d, 16'h0001);
        vp <= 8'h05;
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, irq}, 16'h0000);
        @(posedge clk);
        #1 chk({15'h0000, irq}, 16'h0001);
        @(posedge clk);
        bus_rd(DCC_OFS_CTRL, d);
        chk(d, 16'h1401);
        bus_rd(DCC_OFS_STAT, d);
        chk(d, 16'h0001);
        bus_rd(DCC_OFS_STAT, d);
        chk({d[15:1], irq}, 16'h0000);
        chk(d, 16'h0000);
        bus_wr(DCC_OFS_CTRL, 16'h1401);
        bus_rd(DCC_OFS_CTRL, d);
        chk(d, 16'h1401);
        bus_wr(DCC_OFS_MASK, 16'h0000);
        vp <= 8'h14;
        repeat (6) @(posedge clk);
        bus_rd(DCC_OFS_STAT, d);
        chk({d[15:1], irq}, 16'h0000);
        chk(d, 16'h0001);
        bus_wr(DCC_OFS_CTRL, 16'h0401);
        bus_rd(DCC_OFS_CTRL, d);
        chk(d, 16'h0441);
        bus_rd(4'hF, d);
        chk(d, 16'h0000);
        bus_wr(4'h7, 16'hFFFF);
        bus_rd(DCC_OFS_MASK, d);
        chk(d, 16'h0000);
        bus_wr(DCC_OFS_CTRL, 16'hC0C0);
        repeat (6) @(posedge clk);
        bus_rd(DCC_OFS_CTRL, d);
        chk(d, 16'h8000);
        summarize();
    end
endmodule // test_dual_comparator_control
